// ### src/sync_ctrl_pkg.sv
// constants for the sync and register-update control block
// Contract
// - system bit 2 set powers down channel synchronization circuitry; zero runs normally.
// - system bit 1 set powers down distribution reference; zero runs normally.
// - soft sync bit high forces selected channels static, like align pin low.
// - soft sync bit falling from one to zero triggers a synchronization event.
// - soft sync bit resets to zero, causing no hold and no sync.
// - writing one to update bit copies all buffered values into active registers.
// - transfer happens on first serial clock rising edge after the update write.
// - update bit clears itself after the transfer, no software clear needed.
package sync_ctrl_pkg;
  localparam int          ADDR_W        = 10;
  localparam int          DATA_W        = 8;
  localparam int          NUM_BUF       = 4;
  localparam logic [9:0]  ADDR_SYSCTL   = 10'h230;
  localparam logic [9:0]  ADDR_UPDATE   = 10'h232;
  localparam logic [9:0]  ADDR_BUF_BASE = 10'h240;
  localparam int          BIT_SOFTSYNC  = 0;
  localparam int          BIT_PD_DIST   = 1;
  localparam int          BIT_PD_SYNC   = 2;
  localparam int          BIT_UPDATE    = 0;
  localparam logic [7:0]  SYSCTL_RESET  = 8'h00;
  localparam logic [7:0]  BUF_RESET     = 8'h00;
  localparam logic [7:0]  SYSCTL_MASK   = 8'h07;
  typedef enum logic [1:0] {UPD_IDLE, UPD_ARMED, UPD_DONE} upd_state_t;
endpackage

// ### src/edge_detect.sv
// rising and falling edge detector on a synchronous level
`timescale 1ns/1ns
module edge_detect (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic prev;
  } ed_state_t;
  ed_state_t st;
  ed_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.prev = level;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise = level & ~st.prev;
  assign fall = ~level & st.prev;
endmodule

// ### src/update_sequencer.sv
// waits for a serial clock rising edge and fires the transfer strobe
`timescale 1ns/1ns
module update_sequencer
  import sync_ctrl_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic request,
  input  wire logic sclkRise,
  output logic      pending,
  output logic      transfer
);
  typedef struct packed {
    upd_state_t state;
  } us_state_t;
  us_state_t st;
  us_state_t next_st;

  always_comb begin
    next_st = st;
    case (st.state)
      UPD_IDLE: begin
        if (request) begin
          next_st.state = UPD_ARMED;
        end
      end
      UPD_ARMED: begin
        // a new update write on the transfer edge re-arms
        if (sclkRise) begin
          next_st.state = request ? UPD_ARMED : UPD_DONE;
        end
      end
      UPD_DONE: begin
        next_st.state = request ? UPD_ARMED : UPD_IDLE;
      end
      default: begin
        next_st.state = UPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{state: UPD_IDLE};
    end else begin
      st <= next_st;
    end
  end

  assign pending  = (st.state == UPD_ARMED);
  assign transfer = (st.state == UPD_ARMED) && sclkRise;
endmodule

// ### src/sync_and_register_update_control.sv
// system power, soft sync and buffered register update control
`timescale 1ns/1ns
module sync_and_register_update_control #(
  parameter int NUM_REGS = sync_ctrl_pkg::NUM_BUF
) (
  input  wire logic                              mclk,
  input  wire logic                              rst_b,
  input  wire logic [sync_ctrl_pkg::ADDR_W-1:0]  addr,
  input  wire logic [sync_ctrl_pkg::DATA_W-1:0]  wrData,
  input  wire logic                              wrStb,
  input  wire logic                              rdStb,
  output logic      [sync_ctrl_pkg::DATA_W-1:0]  rdData,
  input  wire logic                              sclk,
  input  wire logic                              alignPin_b,
  output logic                                   syncPowerDown,
  output logic                                   distRefPowerDown,
  output logic                                   channelHold,
  output logic                                   syncEvent,
  output logic                                   syncRequest,
  output logic      [NUM_REGS*sync_ctrl_pkg::DATA_W-1:0] activeRegs
);
  import sync_ctrl_pkg::*;

  localparam int IDX_W = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;

  // refuse sizes the 4-bit buffer index cannot serve
  if (NUM_REGS < 1 || NUM_REGS > 16) begin
    $error("NUM_REGS must be 1 to 16");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  function automatic logic inBuf(input logic [ADDR_W-1:0] a);
    inBuf = (a >= ADDR_BUF_BASE) &&
            (a < ADDR_BUF_BASE + ADDR_W'(NUM_REGS));
  endfunction

  typedef struct packed {
    logic [DATA_W-1:0]                 sysctl;
    logic [NUM_REGS-1:0][DATA_W-1:0]   bufRegs;
    logic [NUM_REGS-1:0][DATA_W-1:0]   actRegs;
    logic [DATA_W-1:0]                 rdData;
    logic                              syncPulse;
  } top_state_t;
  top_state_t st;
  top_state_t next_st;

  logic softSync;
  logic syncLevel;
  logic sclkRise;
  logic upPending;
  logic upTransfer;
  logic upRequest;
  logic syncFall;
  logic [ADDR_W-1:0] bufIdx;

  assign softSync  = st.sysctl[BIT_SOFTSYNC];
  // combined request; pin low or soft bit high
  assign syncLevel = ~alignPin_b | softSync;
  assign upRequest = wrStb && hit(addr, ADDR_UPDATE) &&
                     wrData[BIT_UPDATE];
  assign bufIdx    = addr - ADDR_BUF_BASE;

  edge_detect u_sclk_edge (
    .mclk  (mclk),
    .rst_b (rst_b),
    .level (sclk),
    .rise  (sclkRise),
    .fall  ()
  );

  // release of the combined request is the sync trigger
  edge_detect u_sync_edge (
    .mclk  (mclk),
    .rst_b (rst_b),
    .level (syncLevel),
    .rise  (),
    .fall  (syncFall)
  );

  update_sequencer u_update (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .request  (upRequest),
    .sclkRise (sclkRise),
    .pending  (upPending),
    .transfer (upTransfer)
  );

  always_comb begin
    next_st = st;
    next_st.rdData = '0;
    if (wrStb && hit(addr, ADDR_SYSCTL)) begin
      next_st.sysctl = wrData & SYSCTL_MASK;
    end
    if (wrStb && inBuf(addr)) begin
      next_st.bufRegs[bufIdx[IDX_W-1:0]] = wrData;
    end
    if (upTransfer) begin
      next_st.actRegs = st.bufRegs;
    end
    // combined request falling (soft bit low and pin high), unless sync is powered down
    next_st.syncPulse = syncFall & ~st.sysctl[BIT_PD_SYNC];
    if (rdStb) begin
      if (hit(addr, ADDR_SYSCTL)) begin
        next_st.rdData = st.sysctl;
      end else if (hit(addr, ADDR_UPDATE)) begin
        next_st.rdData = {{(DATA_W-1){1'b0}}, upPending};
      end else if (inBuf(addr)) begin
        next_st.rdData = st.bufRegs[bufIdx[IDX_W-1:0]];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st.sysctl    <= SYSCTL_RESET;
      st.bufRegs   <= {NUM_REGS{BUF_RESET}};
      st.actRegs   <= {NUM_REGS{BUF_RESET}};
      st.rdData    <= '0;
      st.syncPulse <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign rdData           = st.rdData;
  assign syncPowerDown    = st.sysctl[BIT_PD_SYNC];
  assign distRefPowerDown = st.sysctl[BIT_PD_DIST];
  assign channelHold      = syncLevel & ~st.sysctl[BIT_PD_SYNC];
  assign syncEvent        = st.syncPulse;
  assign syncRequest      = syncLevel;
  assign activeRegs       = st.actRegs;
endmodule

// ### testbench/sync_ctrl_properties.sv
// assertions on the sync and update control ports
`timescale 1ns/1ns
module sync_ctrl_properties #(
  parameter int NUM_REGS = 4
) (
  input wire logic                  mclk,
  input wire logic                  rst_b,
  input wire logic [9:0]            addr,
  input wire logic [7:0]            wrData,
  input wire logic                  wrStb,
  input wire logic                  sclk,
  input wire logic                  alignPin_b,
  input wire logic                  syncPowerDown,
  input wire logic                  distRefPowerDown,
  input wire logic                  channelHold,
  input wire logic                  syncEvent,
  input wire logic                  syncRequest,
  input wire logic [NUM_REGS*8-1:0] activeRegs
);
  import sync_ctrl_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire sysWr = wrStb && addr == ADDR_SYSCTL;
  a_pd_sync_write:
    assert property (sysWr |=> syncPowerDown == $past(wrData[2]))
    else $error("sync power-down bit wrong");
  a_pd_dist_write:
    assert property (sysWr |=> distRefPowerDown == $past(wrData[1]))
    else $error("reference power-down bit wrong");
  a_hold_follows_req:
    assert property (channelHold == (syncRequest && !syncPowerDown))
    else $error("channel hold wrong");
  a_req_from_pin:
    assert property (!alignPin_b |-> syncRequest)
    else $error("pin low gives no request");
  a_event_after_fall:
    assert property ($fell(syncRequest) && !syncPowerDown |=> syncEvent)
    else $error("no sync event after request fall");
  a_event_one_cycle:
    assert property (syncEvent |=> !syncEvent)
    else $error("sync event too long");
  a_event_has_cause:
    assert property (syncEvent |-> $past(syncRequest, 2) && !$past(syncRequest))
    else $error("sync event without request fall");
  a_active_on_sclk:
    assert property (!$stable(activeRegs) |-> $past(sclk) && !$past(sclk, 2))
    else $error("active registers moved without serial clock rise");
  c_event: cover property (syncEvent);
  c_update: cover property (!$stable(activeRegs));
  c_pd: cover property ($rose(syncPowerDown));
endmodule

// ### testbench/test_sync_and_register_update_control.sv
// self-checking bench for sync and update control
`timescale 1ns/1ns
module test_sync_and_register_update_control;
  import sync_ctrl_pkg::*;
  logic        mclk = 1'h0, rst_b = 1'h0, sclk = 1'h0, alignPin_b = 1'h1;
  logic        wrStb = 1'h0, rdStb = 1'h0, rdLast = 1'h0;
  logic        syncPowerDown, distRefPowerDown, channelHold;
  logic        syncEvent, syncRequest;
  logic [9:0]  addr = 10'h000;
  logic [7:0]  wrData = 8'h00, rdData, v, exp[$];
  logic [31:0] activeRegs, want;
  int          failures = 0, num_checks = 0, seed = 81, evCnt = 0, k;
  always #50 mclk = ~mclk;
  sync_and_register_update_control dut (.mclk, .rst_b, .addr, .wrData,
    .wrStb, .rdStb, .rdData, .sclk, .alignPin_b, .syncPowerDown,
    .distRefPowerDown, .channelHold, .syncEvent, .syncRequest, .activeRegs);
  task automatic check(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'h1;
    @(posedge mclk);
    wrStb <= 1'h0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge mclk);
    exp.push_back(e);
    addr <= a;
    rdStb <= 1'h1;
    @(posedge mclk);
    rdStb <= 1'h0;
    @(negedge mclk);
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge mclk) rdLast <= rdStb;
  always @(negedge mclk) begin
    if (rdLast) check(rdData, exp.pop_front());
    if (syncEvent === 1'h1) evCnt++;
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'h1;
    rd(ADDR_SYSCTL, 8'h00);
    check(channelHold, 1'h0);
    wr(10'h231, 8'hFF);
    rd(10'h231, 8'h00);
    for (k = 0; k < 4; k++) begin
      v = $random(seed);
      v[2:0] = {k[1:0], 1'h0};
      wr(ADDR_SYSCTL, v);
      rd(ADDR_SYSCTL, v & SYSCTL_MASK);
      check(syncPowerDown, v[2]);
      check(distRefPowerDown, v[1]);
    end
    $display("test power bits done");
    for (k = 0; k < 2; k++) begin
      evCnt = 0;
      wr(ADDR_SYSCTL, {5'h00, k[0], 2'h1});
      check(syncRequest, 1'h1);
      check(channelHold, !k[0]);
      wr(ADDR_SYSCTL, {5'h00, k[0], 2'h0});
      repeat (4) @(negedge mclk);
      check(evCnt, !k[0]);
    end
    wr(ADDR_SYSCTL, 8'h00);
    evCnt = 0;
    @(posedge mclk) alignPin_b <= 1'h0;
    @(negedge mclk) check(syncRequest, 1'h1);
    check(channelHold, 1'h1);
    @(posedge mclk) alignPin_b <= 1'h1;
    repeat (4) @(negedge mclk);
    check(evCnt, 1);
    $display("test sync done");
    for (k = 0; k < NUM_BUF; k++) begin
      v = $random(seed);
      want[k*8+:8] = v;
      wr(ADDR_BUF_BASE + k[9:0], v);
    end
    wr(ADDR_UPDATE, 8'h00);
    rd(ADDR_UPDATE, 8'h00);
    check(activeRegs, 32'h0);
    wr(ADDR_UPDATE, 8'h01);
    rd(ADDR_UPDATE, 8'h01);
    repeat (3) @(negedge mclk);
    check(activeRegs, 32'h0);
    @(posedge mclk) sclk <= 1'h1;
    @(negedge mclk) check(activeRegs, 32'h0);
    @(negedge mclk) check(activeRegs, want);
    rd(ADDR_UPDATE, 8'h00);
    $display("test update done");
    wr(ADDR_SYSCTL, 8'h01);
    check(channelHold, 1'h1);
    evCnt = 0;
    @(posedge mclk) rst_b <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'h1;
    @(negedge mclk) check(channelHold, 1'h0);
    repeat (3) @(negedge mclk);
    check(evCnt, 0);
    rd(ADDR_SYSCTL, 8'h00);
    check(activeRegs, 32'h0);
    $display("test reset done");
    test_done;
  end
endmodule
bind sync_and_register_update_control sync_ctrl_properties #(
  .NUM_REGS(NUM_REGS)
) u_props (.mclk, .rst_b, .addr, .wrData, .wrStb, .sclk, .alignPin_b,
  .syncPowerDown, .distRefPowerDown, .channelHold, .syncEvent,
  .syncRequest, .activeRegs);
